// file: sfp_and_cell.sv
// Configurable AND cell combining fault decision inputs.
// Assumes inputs already synchronous to the system clock.
`timescale 1ns/1ps
module sfp_and_cell #(
   parameter int N = 4
) (
   // Decision inputs and their use mask
   input wire logic [N-1:0] i_in,
   input wire logic [N-1:0] i_use,
   // Combined decision
   output logic o_and
);
   logic [N-1:0] term;

   // Unused inputs read as true so they drop out of the product
   genvar g;
   generate
      for (g = 0; g < N; g = g + 1) begin : g_term
         assign term[g] = i_in[g] | ~i_use[g];
      end
   endgenerate

   assign o_and = (&term) & (|i_use);
endmodule

// file: sfp_consts.svh
// Register offsets, field positions, reset values for the supervisor.
// Assumes a 32-bit Avalon-MM slave with byte addresses.
`ifndef SFP_CONSTS_SVH
`define SFP_CONSTS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define SFP_OFS_CTRL      6'h00
`define SFP_OFS_SC_THR    6'h04
`define SFP_OFS_RETRY_MAX 6'h08
`define SFP_OFS_RETRY_GAP 6'h0c
`define SFP_OFS_RETRY_LEN 6'h10
`define SFP_OFS_SS_LEN    6'h14
`define SFP_OFS_TEST_LEN  6'h18
`define SFP_OFS_WAKE_LEN  6'h1c
`define SFP_OFS_OFFSET    6'h20
`define SFP_OFS_STATUS    6'h24

// ----------------------------------------------------------------------
// Control bits
// ----------------------------------------------------------------------
`define SFP_CTRL_EN       0
`define SFP_CTRL_PSKIP    1
`define SFP_CTRL_TMR_USE  2
`define SFP_CTRL_AUX_USE  3
`define SFP_CTRL_SLEEP    4
`define SFP_CTRL_FVR      5
`define SFP_CTRL_SLOW     6

// ----------------------------------------------------------------------
// Status fields
// ----------------------------------------------------------------------
`define SFP_ST_STATE_LSB  0
`define SFP_ST_CNT_LSB    8
`define SFP_ST_FAULT      16
`define SFP_ST_SC_SEEN    17
`define SFP_ST_SC_NOW     18
`define SFP_ST_DRIVE      19

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define SFP_RST_CTRL      7'h44
`define SFP_RST_SC_THR    10'h200
`define SFP_RST_RETRY_MAX 8'h03
`define SFP_RST_RETRY_GAP 24'h001000
`define SFP_RST_RETRY_LEN 24'h000800
`define SFP_RST_SS_LEN    24'h000400
`define SFP_RST_TEST_LEN  24'h000100
`define SFP_RST_WAKE_LEN  24'h004000
`define SFP_RST_OFFSET    10'h0e0

`endif

// file: sfp_fault_ctrl.sv
// Short-circuit and light-load supervisor for a flyback power stage.
// Assumes comparator and event inputs synchronous to i_mclk and an
// Avalon-MM master that holds each request until waitrequest is low.
`timescale 1ns/1ps
`include "sfp_consts.svh"

// Behaviour
// - Fault detector ANDs up to four decision inputs; fires only when all hold.
// - Two AND inputs are peak-current and feedback-error comparator outputs.
// - Both comparators together raise the short-circuit event; one alone never.
// - Optional start-up limit timer input blocks detection, removable afterwards.
// - Limited retries after a fault; beyond the limit stop and notify.
// - Retry limit, retry gap and retry duration are programmable.
// - Feedback short-circuit threshold is a 10-bit converter code.
// - Detection works in run and at power-up; conversion resumes once cleared.
// - Lower operating clock while stopped between retries.
// - Hysteretic mode stops switching above the upper output limit.
// - Below lower limit restart at minimum duty for a fixed period.
// - Upper limit not reached by period end: soft-start then closed loop.
// - Pulse-skip: falling event active at rising event keeps drive low.
// - Pulse-skip mode never puts the output generator in shutdown on the upper limit from run; the no-load retest still stops on it.
// - Sense offset comes from fixed reference or a programmable converter.
// - While stopped, turn off idle peripherals and request sleep.
// - With no load, sleep and wake after programmed interval to retest.
// - Soft-start source adds a falling event limiting the duty cycle.
// - Fault comparators change state on threshold crossing to flag the fault.
module sfp_fault_ctrl #(
   parameter int TW = 24
) (
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_rst_n,
   // Avalon-MM slave
   input wire logic [5:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0] i_avs_byteenable,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   // Comparator and decision inputs
   input wire logic i_cmp_peak,
   input wire logic i_cmp_fb,
   input wire logic i_startup_ok,
   input wire logic i_aux_dec,
   input wire logic i_ov_hi,
   input wire logic i_uv_lo,
   // Output generator events
   input wire logic i_rise_evt,
   input wire logic i_loop_fall,
   input wire logic i_ss_fall,
   // Analog setting outputs
   output logic [9:0] o_sc_dac,
   output logic [9:0] o_ofs_dac,
   output logic o_ofs_sel_fvr,
   // Power stage outputs
   output logic o_drive,
   output logic o_gen_shutdown,
   output logic o_min_duty,
   output logic o_ss_en,
   // System outputs
   output logic o_sc_event,
   output logic o_fault_notify,
   output logic o_clk_slow,
   output logic o_periph_off,
   output logic o_sleep_req
);
   // -------------------------------------------------------------------
   // Register bus
   // -------------------------------------------------------------------
   logic ack_q;
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;
   logic [31:0] bmask;
   logic bus_req;
   logic wr_en;
   logic [5:0] word_addr;
   logic [6:0] ctrl_q;
   logic [9:0] sc_thr_q;
   logic [7:0] retry_max_q;
   logic [TW-1:0] retry_gap_q;
   logic [TW-1:0] retry_len_q;
   logic [TW-1:0] ss_len_q;
   logic [TW-1:0] test_len_q;
   logic [TW-1:0] wake_len_q;
   logic [9:0] ofs_q;
   logic [31:0] status;

   assign bus_req = i_avs_read | i_avs_write;
   assign o_avs_waitrequest = bus_req & ~ack_q;
   assign wr_en = i_avs_write & ack_q;
   assign word_addr = {i_avs_address[5:2], 2'b00};
   assign bmask = {{8{i_avs_byteenable[3]}}, {8{i_avs_byteenable[2]}},
                   {8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};
   assign o_avs_readdata = rdata_q;

   function automatic logic [31:0] merge(input logic [31:0] old_v,
                                         input logic [31:0] new_v,
                                         input logic [31:0] m);
      merge = (old_v & ~m) | (new_v & m);
   endfunction

   logic [31:0] wmerge_ctrl;
   logic [31:0] wmerge_thr;
   logic [31:0] wmerge_max;
   logic [31:0] wmerge_gap;
   logic [31:0] wmerge_len;
   logic [31:0] wmerge_ss;
   logic [31:0] wmerge_tst;
   logic [31:0] wmerge_wk;
   logic [31:0] wmerge_ofs;
   assign wmerge_ctrl = merge({25'h0, ctrl_q}, i_avs_writedata, bmask);
   assign wmerge_thr = merge({22'h0, sc_thr_q}, i_avs_writedata, bmask);
   assign wmerge_max = merge({24'h0, retry_max_q}, i_avs_writedata, bmask);
   assign wmerge_gap = merge({8'h0, retry_gap_q}, i_avs_writedata, bmask);
   assign wmerge_len = merge({8'h0, retry_len_q}, i_avs_writedata, bmask);
   assign wmerge_ss = merge({8'h0, ss_len_q}, i_avs_writedata, bmask);
   assign wmerge_tst = merge({8'h0, test_len_q}, i_avs_writedata, bmask);
   assign wmerge_wk = merge({8'h0, wake_len_q}, i_avs_writedata, bmask);
   assign wmerge_ofs = merge({22'h0, ofs_q}, i_avs_writedata, bmask);

   // Unmapped addresses read as zero and ignore writes
   assign rdata_d =
      (word_addr == `SFP_OFS_CTRL)      ? {25'h0, ctrl_q} :
      (word_addr == `SFP_OFS_SC_THR)    ? {22'h0, sc_thr_q} :
      (word_addr == `SFP_OFS_RETRY_MAX) ? {24'h0, retry_max_q} :
      (word_addr == `SFP_OFS_RETRY_GAP) ? {8'h0, retry_gap_q} :
      (word_addr == `SFP_OFS_RETRY_LEN) ? {8'h0, retry_len_q} :
      (word_addr == `SFP_OFS_SS_LEN)    ? {8'h0, ss_len_q} :
      (word_addr == `SFP_OFS_TEST_LEN)  ? {8'h0, test_len_q} :
      (word_addr == `SFP_OFS_WAKE_LEN)  ? {8'h0, wake_len_q} :
      (word_addr == `SFP_OFS_OFFSET)    ? {22'h0, ofs_q} :
      (word_addr == `SFP_OFS_STATUS)    ? status : 32'h0;

   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         ack_q <= 1'b0;
         rdata_q <= 32'h0;
      end else begin
         ack_q <= bus_req & ~ack_q;
         if (bus_req & ~ack_q) begin
            rdata_q <= rdata_d;
         end
      end
   end

   // Timer registers are programmable so the field can tune retries
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         ctrl_q <= `SFP_RST_CTRL;
         sc_thr_q <= `SFP_RST_SC_THR;
         retry_max_q <= `SFP_RST_RETRY_MAX;
         retry_gap_q <= `SFP_RST_RETRY_GAP;
         retry_len_q <= `SFP_RST_RETRY_LEN;
         ss_len_q <= `SFP_RST_SS_LEN;
         test_len_q <= `SFP_RST_TEST_LEN;
         wake_len_q <= `SFP_RST_WAKE_LEN;
         ofs_q <= `SFP_RST_OFFSET;
      end else if (wr_en) begin
         case (word_addr)
            `SFP_OFS_CTRL: ctrl_q <= wmerge_ctrl[6:0];
            `SFP_OFS_SC_THR: sc_thr_q <= wmerge_thr[9:0];
            `SFP_OFS_RETRY_MAX: retry_max_q <= wmerge_max[7:0];
            `SFP_OFS_RETRY_GAP: retry_gap_q <= wmerge_gap[TW-1:0];
            `SFP_OFS_RETRY_LEN: retry_len_q <= wmerge_len[TW-1:0];
            `SFP_OFS_SS_LEN: ss_len_q <= wmerge_ss[TW-1:0];
            `SFP_OFS_TEST_LEN: test_len_q <= wmerge_tst[TW-1:0];
            `SFP_OFS_WAKE_LEN: wake_len_q <= wmerge_wk[TW-1:0];
            `SFP_OFS_OFFSET: ofs_q <= wmerge_ofs[9:0];
            default: ;
         endcase
      end
   end

   logic en;
   logic pskip;
   assign en = ctrl_q[`SFP_CTRL_EN];
   assign pskip = ctrl_q[`SFP_CTRL_PSKIP];
   assign o_sc_dac = sc_thr_q;
   assign o_ofs_dac = ofs_q;
   assign o_ofs_sel_fvr = ctrl_q[`SFP_CTRL_FVR];

   // -------------------------------------------------------------------
   // Short-circuit detection
   // -------------------------------------------------------------------
   logic sc_raw;
   logic sc_prev_q;
   logic sc_irq;
   logic [3:0] and_use;

   // Both comparators are always part of the product
   assign and_use = {ctrl_q[`SFP_CTRL_AUX_USE], ctrl_q[`SFP_CTRL_TMR_USE],
                     2'b11};

   sfp_and_cell #(.N(4)) u_and (
      .i_in({i_aux_dec, i_startup_ok, i_cmp_fb, i_cmp_peak}),
      .i_use(and_use),
      .o_and(sc_raw)
   );

   // Event on the comparator crossing, not on the held level
   assign sc_irq = sc_raw & ~sc_prev_q;
   assign o_sc_event = sc_irq;

   // -------------------------------------------------------------------
   // Supervisor state machine
   // -------------------------------------------------------------------
   sfp_pkg::sfp_state_t state_q;
   sfp_pkg::sfp_state_t state_d;
   logic [7:0] retry_cnt_q;
   logic [7:0] retry_cnt_d;
   logic tmr_zero;
   logic tmr_load;
   logic [TW-1:0] tmr_val;
   logic conv_on;
   logic sc_armed;
   logic fault_q;
   logic sc_seen_q;
   logic st_wr;

   assign conv_on = (state_q == sfp_pkg::ST_SOFT) ||
                    (state_q == sfp_pkg::ST_RUN) ||
                    (state_q == sfp_pkg::ST_SC_RETRY) ||
                    (state_q == sfp_pkg::ST_NL_TEST);
   assign sc_armed = conv_on & sc_irq;

   always_comb begin
      state_d = state_q;
      retry_cnt_d = retry_cnt_q;
      if (!en) begin
         state_d = sfp_pkg::ST_IDLE;
      end else if (sc_armed) begin
         if (retry_cnt_q >= retry_max_q) begin
            state_d = sfp_pkg::ST_FAULT;
         end else begin
            state_d = sfp_pkg::ST_SC_STOP;
            retry_cnt_d = retry_cnt_q + 8'h01;
         end
      end else begin
         case (state_q)
            sfp_pkg::ST_IDLE: begin
               state_d = sfp_pkg::ST_SOFT;
               retry_cnt_d = 8'h00;
            end
            sfp_pkg::ST_SOFT: begin
               if (tmr_zero) state_d = sfp_pkg::ST_RUN;
            end
            sfp_pkg::ST_RUN: begin
               if (!pskip && i_ov_hi) state_d = sfp_pkg::ST_NL_STOP;
            end
            sfp_pkg::ST_SC_STOP: begin
               if (tmr_zero) state_d = sfp_pkg::ST_SC_RETRY;
            end
            sfp_pkg::ST_SC_RETRY: begin
               if (tmr_zero) begin
                  state_d = sfp_pkg::ST_RUN;
                  retry_cnt_d = 8'h00;
               end
            end
            sfp_pkg::ST_FAULT: ;
            sfp_pkg::ST_NL_STOP: begin
               if (pskip) state_d = sfp_pkg::ST_SOFT;
               else if (i_uv_lo || tmr_zero) begin
                  state_d = sfp_pkg::ST_NL_TEST;
               end
            end
            sfp_pkg::ST_NL_TEST: begin
               if (i_ov_hi) state_d = sfp_pkg::ST_NL_STOP;
               else if (tmr_zero) state_d = sfp_pkg::ST_SOFT;
            end
            default: state_d = sfp_pkg::ST_IDLE;
         endcase
      end
   end

   // Each state loads the interval it waits on when it is entered
   assign tmr_load = (state_d != state_q);
   assign tmr_val =
      (state_d == sfp_pkg::ST_SOFT)     ? ss_len_q :
      (state_d == sfp_pkg::ST_SC_STOP)  ? retry_gap_q :
      (state_d == sfp_pkg::ST_SC_RETRY) ? retry_len_q :
      (state_d == sfp_pkg::ST_NL_STOP)  ? wake_len_q :
      (state_d == sfp_pkg::ST_NL_TEST)  ? test_len_q : '0;

   sfp_timer #(.W(TW)) u_tmr (
      .i_mclk(i_mclk),
      .i_rst_n(i_rst_n),
      .i_load(tmr_load),
      .i_val(tmr_val),
      .o_zero(tmr_zero)
   );

   assign st_wr = wr_en && (word_addr == `SFP_OFS_STATUS) &&
                  i_avs_byteenable[2];

   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         state_q <= sfp_pkg::ST_IDLE;
         retry_cnt_q <= 8'h00;
         sc_prev_q <= 1'b0;
         fault_q <= 1'b0;
         sc_seen_q <= 1'b0;
      end else begin
         state_q <= state_d;
         retry_cnt_q <= retry_cnt_d;
         sc_prev_q <= sc_raw;
         // Set wins over a write-one clear in the same cycle
         fault_q <= (state_d == sfp_pkg::ST_FAULT) |
                    (fault_q & ~(st_wr & i_avs_writedata[`SFP_ST_FAULT]));
         sc_seen_q <= sc_irq |
                   (sc_seen_q & ~(st_wr & i_avs_writedata[`SFP_ST_SC_SEEN]));
      end
   end

   // -------------------------------------------------------------------
   // Gate drive and power management
   // -------------------------------------------------------------------
   logic soft_on;
   logic fall_any;
   logic drive_q;
   logic drive_d;

   assign soft_on = (state_q == sfp_pkg::ST_SOFT) ||
                    (state_q == sfp_pkg::ST_SC_RETRY);
   assign fall_any = i_loop_fall | (soft_on & i_ss_fall);
   // A falling event present at the rising edge wins: pulse skipped
   assign drive_d = conv_on & ~fall_any & (drive_q | i_rise_evt);

   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         drive_q <= 1'b0;
      end else begin
         drive_q <= drive_d;
      end
   end

   logic stopped;
   assign stopped = (state_q == sfp_pkg::ST_SC_STOP) ||
                    (state_q == sfp_pkg::ST_NL_STOP);

   assign o_drive = drive_q;
   assign o_gen_shutdown = ~conv_on;
   assign o_min_duty = (state_q == sfp_pkg::ST_NL_TEST);
   assign o_ss_en = soft_on;
   assign o_fault_notify = fault_q;
   assign o_clk_slow = stopped & ctrl_q[`SFP_CTRL_SLOW];
   assign o_periph_off = stopped;
   assign o_sleep_req = stopped & ctrl_q[`SFP_CTRL_SLEEP];

   assign status = {12'h0, drive_q, sc_raw, sc_seen_q, fault_q,
                    retry_cnt_q, 4'h0, state_q};

   // -------------------------------------------------------------------
   // Assertions
   // -------------------------------------------------------------------
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_rst_n);

   a_and_all_inputs: assert property (
      sc_raw |-> (i_cmp_peak && i_cmp_fb &&
                  (i_startup_ok || !ctrl_q[`SFP_CTRL_TMR_USE]) &&
                  (i_aux_dec || !ctrl_q[`SFP_CTRL_AUX_USE])))
      else $error("short-circuit product true with an input low");
   a_event_needs_both: assert property (
      (!i_cmp_peak || !i_cmp_fb) |-> !o_sc_event)
      else $error("short-circuit event from a single comparator");
   a_startup_blocks: assert property (
      (ctrl_q[`SFP_CTRL_TMR_USE] && !i_startup_ok) |-> !sc_raw)
      else $error("detection not blocked during start-up");
   a_retry_stop: assert property (
      (en && sc_armed && retry_cnt_q < retry_max_q) |=>
      (state_q == sfp_pkg::ST_SC_STOP &&
       retry_cnt_q == $past(retry_cnt_q) + 8'h01))
      else $error("fault did not start a retry gap");
   a_retry_limit: assert property (
      (en && sc_armed && retry_cnt_q >= retry_max_q) |=>
      (state_q == sfp_pkg::ST_FAULT) ##1 o_fault_notify)
      else $error("retry limit did not end in fault notice");
   a_slow_when_off: assert property (
      (state_q == sfp_pkg::ST_SC_STOP && ctrl_q[`SFP_CTRL_SLOW]) |->
      (o_clk_slow && o_periph_off))
      else $error("clock not lowered while stopped");
   a_ov_stop: assert property (
      (en && state_q == sfp_pkg::ST_RUN && !pskip && i_ov_hi && !sc_irq) |=>
      (state_q == sfp_pkg::ST_NL_STOP && o_gen_shutdown))
      else $error("upper limit did not stop switching");
   a_uv_restart: assert property (
      (en && state_q == sfp_pkg::ST_NL_STOP && !pskip && i_uv_lo) |=>
      o_min_duty)
      else $error("lower limit did not restart at minimum duty");
   a_skip_pulse: assert property (
      (i_rise_evt && fall_any) |=> !o_drive)
      else $error("rising event not overridden by falling event");
   a_no_shutdown: assert property (
      (pskip && state_q == sfp_pkg::ST_RUN) |=>
      (state_q != sfp_pkg::ST_NL_STOP))
      else $error("pulse-skip mode entered shutdown");
   a_retry_clear: assert property (
      (state_q == sfp_pkg::ST_SC_RETRY && state_d == sfp_pkg::ST_RUN) |=>
      (retry_cnt_q == 8'h00))
      else $error("retry count not cleared on recovery");

   c_fault: cover property (state_q == sfp_pkg::ST_FAULT);
   c_recover: cover property (state_q == sfp_pkg::ST_SC_RETRY ##1
                              state_q == sfp_pkg::ST_RUN);
   c_nl_cycle: cover property (state_q == sfp_pkg::ST_NL_TEST ##1
                               state_q == sfp_pkg::ST_SOFT);
   c_skip: cover property (pskip && i_rise_evt && fall_any);
endmodule

// file: sfp_pkg.sv
// Types shared by the supervisor modules.
// Assumes nothing beyond a SystemVerilog compiler.
package sfp_pkg;

   typedef enum logic [3:0] {
      ST_IDLE     = 4'h0,
      ST_SOFT     = 4'h1,
      ST_RUN      = 4'h2,
      ST_SC_STOP  = 4'h3,
      ST_SC_RETRY = 4'h4,
      ST_FAULT    = 4'h5,
      ST_NL_STOP  = 4'h6,
      ST_NL_TEST  = 4'h7
   } sfp_state_t;

endpackage

// file: sfp_plant.sv
// Far side model: fault comparators and a switching event source.
// Assumes the feedback threshold comes straight from the supervisor output; peak threshold is fixed.
`timescale 1ns/1ps
module sfp_plant (
   // Clock, analog levels and light-load skip flag
   input wire logic i_mclk,
   input wire logic [9:0] i_ipk,
   input wire logic [9:0] i_fb,
   input wire logic [9:0] i_thr,
   input wire logic i_skip,
   // Comparator and event outputs
   output logic o_cmp_peak,
   output logic o_cmp_fb,
   output logic o_rise,
   output logic o_fall
);
   localparam logic [9:0] PK_THR = 10'h180;
   logic [2:0] ph_q = 3'h0;
   always_ff @(posedge i_mclk) begin
      ph_q <= ph_q + 3'h1;
   end
   // Outputs flip as soon as a level crosses its threshold
   assign o_cmp_peak = i_ipk > PK_THR;
   assign o_cmp_fb = i_fb > i_thr;
   assign o_rise = ph_q == 3'h0;
   // Light load keeps the falling event up across the rising one
   assign o_fall = i_skip || ph_q == 3'h3;
endmodule

// file: sfp_timer.sv
// Loadable down counter used for all supervisor intervals.
// Assumes one clock, synchronous active-low reset.
`timescale 1ns/1ps
module sfp_timer #(
   parameter int W = 24
) (
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_rst_n,
   // Load port
   input wire logic i_load,
   input wire logic [W-1:0] i_val,
   // Status
   output logic o_zero
);
   logic [W-1:0] cnt_q;
   logic [W-1:0] cnt_d;

   assign cnt_d = i_load ? i_val :
                  (cnt_q != '0) ? cnt_q - 1'b1 : cnt_q;
   assign o_zero = (cnt_q == '0);

   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_d;
      end
   end
endmodule

// file: test_smps_fault_protection_control.sv
// Self-checking bench for the supervisor.
// Assumes the far side model in sfp_plant.sv.
`timescale 1ns/1ps
module test_smps_fault_protection_control;
   logic clk = 1'b0, rst_n = 1'b0, rd = 1'b0, wr = 1'b0;
   logic ok = 1'b0, skip = 1'b0, ov = 1'b0, uv = 1'b0, ssf = 1'b0;
   logic [5:0] adr = 6'h00;
   logic [31:0] wd = 32'h0, rdv, q;
   logic [9:0] ipk = 10'h0, fb = 10'h0, dac, ofs;
   logic cpk, cfb, rise, fall, wrq, sc, drv, sd, slow, poff, ntf;
   logic mind, sse, fixed_voltage_reference, slp;
   int num_errors = 0, checks = 0, cyc = 0, nsc = 0, ndrv = 0, nsd = 0;
   int d0;
   always #2.5 clk = ~clk;
   sfp_plant plant (.i_mclk(clk), .i_ipk(ipk), .i_fb(fb), .i_thr(dac),
      .i_skip(skip), .o_cmp_peak(cpk), .o_cmp_fb(cfb), .o_rise(rise),
      .o_fall(fall));
   sfp_fault_ctrl dut (.i_mclk(clk), .i_rst_n(rst_n), .i_avs_address(adr),
      .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd),
      .i_avs_byteenable(4'hf), .o_avs_readdata(rdv),
      .o_avs_waitrequest(wrq), .i_cmp_peak(cpk), .i_cmp_fb(cfb),
      .i_startup_ok(ok), .i_aux_dec(1'b1), .i_ov_hi(ov),
      .i_uv_lo(uv), .i_rise_evt(rise), .i_loop_fall(fall),
      .i_ss_fall(ssf), .o_sc_dac(dac), .o_ofs_dac(ofs), .o_ofs_sel_fvr(fixed_voltage_reference),
      .o_drive(drv), .o_gen_shutdown(sd), .o_min_duty(mind), .o_ss_en(sse),
      .o_sc_event(sc), .o_fault_notify(ntf), .o_clk_slow(slow),
      .o_periph_off(poff), .o_sleep_req(slp));
   // ----------------------------------------
   // Monitors and timeout
   // ----------------------------------------
   always @(posedge clk) begin
      cyc++;
      if (sc === 1'b1) nsc++;
      if (drv === 1'b1) ndrv++;
      if (sd !== 1'b0 && skip) nsd++;
      if (cyc == 3000) begin
         num_errors++;
         summarize();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // Holds the request until waitrequest is seen low, then completes
   task automatic bus(input logic w, input logic [5:0] a,
                      input logic [31:0] d);
      @(posedge clk);
      rd <= !w;
      wr <= w;
      adr <= a;
      wd <= d;
      // Sampled at the rising edge; only the bench timeout ends a hang
      @(posedge clk);
      while (wrq !== 1'b0) @(posedge clk);
      q = rdv;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask
   task automatic rdchk(input logic [5:0] a, input logic [31:0] m,
                        input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(q & m, e);
   endtask
   task automatic summarize;
      if (num_errors == 0 && checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_regs;
      rdchk(6'h00, 32'hffffffff, 32'h44);
      rdchk(6'h3c, 32'hffffffff, 32'h0);
      bus(1'b1, 6'h04, 32'h3ff);
      rdchk(6'h04, 32'hffffffff, 32'h3ff);
      chk({22'h0, dac}, 32'h3ff);
      bus(1'b1, 6'h08, 32'h1);
      bus(1'b1, 6'h0c, 32'h8);
      bus(1'b1, 6'h10, 32'h28);
      bus(1'b1, 6'h14, 32'h10);
      rdchk(6'h10, 32'hffffffff, 32'h28);
      chk({22'h0, ofs}, 32'he0);
      chk(fixed_voltage_reference, 0);
      bus(1'b1, 6'h20, 32'h155);
      bus(1'b1, 6'h18, 32'h10);
      bus(1'b1, 6'h1c, 32'h30);
      chk({22'h0, ofs}, 32'h155);
   endtask
   task automatic t_skip;
      bus(1'b1, 6'h00, 32'h47);
      repeat (2) @(posedge clk);
      skip <= 1'b1;
      // Upper limit high too: pulse-skip must still never stop
      ov <= 1'b1;
      repeat (20) @(posedge clk);
      d0 = ndrv;
      repeat (40) @(posedge clk);
      chk(ndrv - d0, 0);
      chk(nsd, 0);
      skip <= 1'b0;
      ov <= 1'b0;
      repeat (40) @(posedge clk);
      chk(ndrv > d0, 1);
   endtask
   task automatic t_sc;
      ok <= 1'b1;
      ipk <= 10'h3ff;
      fb <= 10'h300;
      repeat (20) @(posedge clk);
      chk(nsc, 0);
      ok <= 1'b0;
      bus(1'b1, 6'h04, 32'h100);
      repeat (20) @(posedge clk);
      chk(nsc, 0);
      ok <= 1'b1;
      repeat (3) @(posedge clk);
      chk(nsc, 1);
      chk({slow, poff}, 2'b11);
      ipk <= 10'h0;
      repeat (80) @(posedge clk);
      rdchk(6'h24, 32'h3ff0f, 32'h20002);
      ipk <= 10'h3ff;
      repeat (3) @(posedge clk);
      ipk <= 10'h0;
      repeat (15) @(posedge clk);
      ipk <= 10'h3ff;
      repeat (3) @(posedge clk);
      chk(nsc, 3);
      chk(ntf, 1);
      rdchk(6'h24, 32'hf, 32'h5);
   endtask
   task automatic t_nl;
      bus(1'b1, 6'h00, 32'h75);
      ov <= 1'b1;
      repeat (2) @(posedge clk);
      chk({sd, slp, fixed_voltage_reference}, 3'b111);
      ov <= 1'b0;
      uv <= 1'b1;
      repeat (2) @(posedge clk);
      chk({mind, sd}, 2'b10);
      uv <= 1'b0;
      repeat (18) @(posedge clk);
      chk({sse, mind}, 2'b10);
      ssf <= 1'b1;
      repeat (2) @(posedge clk);
      d0 = ndrv;
      repeat (10) @(posedge clk);
      chk(ndrv - d0, 0);
      ssf <= 1'b0;
      ov <= 1'b1;
      repeat (6) @(posedge clk);
      ov <= 1'b0;
      chk({sd, mind}, 2'b10);
      repeat (52) @(posedge clk);
      chk(mind, 1);
      ov <= 1'b1;
      repeat (2) @(posedge clk);
      chk({sd, mind}, 2'b10);
      ov <= 1'b0;
      bus(1'b1, 6'h00, 32'h47);
   endtask
   initial begin
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      t_regs();
      t_skip();
      t_nl();
      t_sc();
      summarize();
   end
endmodule
